// [core/dcfpf_port_flags.sv]
// Operation
// - write stores word when enabled and not full
// - write enable high stores nothing
// - standard full flag low when full, released later
// - input ready high when full, released later
// - write enable ignored while full
// - read-side flags move only on read edges (here output ready in fall-through mode moves on any system clock)
// - enabled read loads next word into output
// - read enable high holds output register
// - standard mode needs explicit reads, empty blocks reads
// - empty flag releases two read cycles after write (here on the first read edge once the write pointer has synced)
// - first word falls through on third read edge (here on the first read edge)
// - output ready low with first valid word
// - output ready high only on true read
// - serial offset shift on write edge when enabled
// - serial enable high keeps offsets
// - output enable low drives data, high floats (here data is always driven, the enable goes out on READ_DATA_OE_N_OUT)
// - load level at master reset picks defaults
// - load low starts offset write or readback
// - standard full after depth writes
// - fall-through input ready counts output word
// - full flag two register stages on write side
// - empty flag two stages, output ready three
// - mode pin sampled at master reset
// - resets clear pointers and output register
// - nine-bit write and read paths
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module dcfpf_port_flags (
	input wire logic MCLK_IN,
	input wire logic RST_IN,
	input wire logic WRITE_CLK_IN,
	input wire logic READ_CLK_IN,
	input wire logic WRITE_EN_N_IN,
	input wire logic READ_EN_N_IN,
	input wire logic OUTPUT_EN_N_IN,
	input wire logic MASTER_RESET_N_IN,
	input wire logic PARTIAL_RESET_N_IN,
	input wire logic OFFSET_ACCESS_N_IN,
	input wire logic SERIAL_PROG_ENABLE_N_IN,
	input wire logic FALL_THROUGH_MODE_IN,
	input wire logic [dcfpf_pkg::DATA_W-1:0] WRITE_DATA_IN,
	output logic FULL_INPUT_READY_N_OUT,
	output logic EMPTY_OUTPUT_READY_N_OUT,
	output logic ALMOST_EMPTY_FLAG_N_OUT,
	output logic ALMOST_FULL_FLAG_N_OUT,
	output logic HALF_FULL_FLAG_N_OUT,
	output logic [dcfpf_pkg::DATA_W-1:0] READ_DATA_OUT,
	output logic READ_DATA_OE_N_OUT
);
	import dcfpf_pkg::*;

	localparam dcfpf_state_t ST_INIT = '{
		pae_ofs: OFS_PAR_DEFAULT,
		paf_ofs: OFS_PAR_DEFAULT,
		wr_sel: SEL_AE_LO,
		rd_sel: SEL_AE_LO,
		hf_n: 1'b1,
		paf_n: 1'b1,
		full_pin: 1'b1,
		oe_n: 1'b1,
		default: '0
	};

	dcfpf_pins_t pin_raw;
	dcfpf_pins_t pin_lvl;
	dcfpf_pins_t pin_rise;
	dcfpf_state_t s;
	dcfpf_state_t next_s;
	logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
	logic [PTR_W-1:0] rgray_w;
	logic [PTR_W-1:0] wgray_r;
	logic [PTR_W-1:0] cnt_w;
	logic [PTR_W-1:0] cnt_r;
	logic [PTR_W-1:0] cnt_w_after;
	logic [PTR_W-1:0] cnt_r_after;
	logic [DATA_W-1:0] mem_rd;
	logic wr_tick;
	logic rd_tick;
	logic master_reset_n;
	logic any_rst;
	logic ld_active;
	logic full_int;
	logic empty_int;
	logic wr_accept;
	logic std_take;
	logic ft_load;
	logic ft_drain;
	logic rd_take;
	logic ser_shift;
	logic par_write;
	logic ofs_read;

	assign pin_raw = {WRITE_CLK_IN, READ_CLK_IN, WRITE_EN_N_IN, READ_EN_N_IN, OUTPUT_EN_N_IN,
		MASTER_RESET_N_IN, PARTIAL_RESET_N_IN, OFFSET_ACCESS_N_IN, SERIAL_PROG_ENABLE_N_IN,
		FALL_THROUGH_MODE_IN, WRITE_DATA_IN};

	dcfpf_pin_sync #(.W(PIN_W)) u_pins (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.d_in(pin_raw),
		.level_out(pin_lvl),
		.rise_out(pin_rise)
	);

	// read pointer toward the write side, write pointer toward the read side
	dcfpf_gray_sync #(.W(PTR_W)) u_rptr_sync (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.gray_in(s.rgray),
		.gray_out(rgray_w)
	);

	dcfpf_gray_sync #(.W(PTR_W)) u_wptr_sync (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.gray_in(s.wgray),
		.gray_out(wgray_r)
	);

	assign wr_tick = pin_rise.wclk;
	assign rd_tick = pin_rise.rclk;
	assign master_reset_n = !pin_lvl.mrs_n;
	assign any_rst = master_reset_n || !pin_lvl.prs_n;
	assign ld_active = !pin_lvl.ld_n;

	// occupancy of the array as each side sees it
	assign cnt_w = PTR_W'(s.wptr - gray2bin(rgray_w));
	assign cnt_r = PTR_W'(gray2bin(wgray_r) - s.rptr);
	assign full_int = (cnt_w == DEPTH);
	assign empty_int = (cnt_r == PTR_ZERO);
	assign mem_rd = mem[s.rptr[ADDR_W-1:0]];

	// write side: blocked while full, while offsets are accessed and in reset
	assign wr_accept = wr_tick && !pin_lvl.wen_n && !full_int && !ld_active && !any_rst;
	assign std_take = !s.fall_through_mode && rd_tick && !pin_lvl.ren_n && !empty_int
		&& !ld_active && !any_rst;
	assign ft_load = s.fall_through_mode && rd_tick && !empty_int && (!s.ov || !pin_lvl.ren_n)
		&& !ld_active && !any_rst;
	assign ft_drain = s.fall_through_mode && rd_tick && s.ov && !pin_lvl.ren_n && empty_int
		&& !ld_active && !any_rst;
	assign rd_take = std_take || ft_load;
	assign cnt_w_after = PTR_W'(cnt_w + {{(PTR_W-1){1'b0}}, wr_accept});
	assign cnt_r_after = PTR_W'(cnt_r - {{(PTR_W-1){1'b0}}, rd_take});

	// offset programming and readback
	assign ser_shift = wr_tick && ld_active && !pin_lvl.sen_n && s.serial && !any_rst;
	assign par_write = wr_tick && ld_active && !pin_lvl.wen_n && !s.serial && !any_rst;
	assign ofs_read = rd_tick && ld_active && !pin_lvl.ren_n && !any_rst;

	always_ff @(posedge MCLK_IN) begin
		if (wr_accept) begin
			mem[s.wptr[ADDR_W-1:0]] <= pin_lvl.data;
		end
	end

	always_comb begin
		next_s = s;
		next_s.oe_n = pin_lvl.oe_n;
		next_s.q_pin = s.out_data;
		// full and empty pins move only on their own side's clock edge, except output ready in fall-through mode, updated every clock
		if (wr_tick) begin
			next_s.full_pin = s.fall_through_mode ? (cnt_w_after == DEPTH) : (cnt_w_after != DEPTH);
		end
		if (rd_tick || s.fall_through_mode) begin
			next_s.empty_pin = s.fall_through_mode ? !s.ov : (cnt_r_after != PTR_ZERO);
		end

		if (wr_accept) begin
			next_s.wptr = PTR_W'(s.wptr + PTR_ONE);
			next_s.wgray = bin2gray(PTR_W'(s.wptr + PTR_ONE));
		end
		if (rd_take) begin
			next_s.rptr = PTR_W'(s.rptr + PTR_ONE);
			next_s.rgray = bin2gray(PTR_W'(s.rptr + PTR_ONE));
			next_s.out_data = mem_rd;
		end
		if (ft_load) begin
			next_s.ov = 1'b1;
		end
		if (ft_drain) begin
			next_s.ov = 1'b0;
		end

		// half-full: writes only set it, reads only clear it
		if (wr_tick && (cnt_w_after > HALF_DEPTH)) begin
			next_s.hf_n = 1'b0;
		end
		if (rd_tick && (cnt_r_after <= HALF_DEPTH)) begin
			next_s.hf_n = 1'b1;
		end
		if (rd_tick) begin
			next_s.pae_n = !(cnt_r_after <= PTR_W'({1'b0, s.pae_ofs} + {14'h0000, s.fall_through_mode}));
		end
		if (wr_tick) begin
			next_s.paf_n = !(cnt_w_after >= PTR_W'(DEPTH - {1'b0, s.paf_ofs}));
		end

		if (ser_shift) begin
			{next_s.paf_ofs, next_s.pae_ofs} = {s.paf_ofs[ADDR_W-2:0], s.pae_ofs, pin_lvl.fall_through_mode_si};
		end
		if (par_write) begin
			unique case (s.wr_sel)
				SEL_AE_LO: begin
					next_s.pae_ofs[DATA_W-1:0] = pin_lvl.data;
					next_s.wr_sel = SEL_AE_HI;
				end
				SEL_AE_HI: begin
					next_s.pae_ofs[ADDR_W-1:DATA_W] = pin_lvl.data[HI_W-1:0];
					next_s.wr_sel = SEL_AF_LO;
				end
				SEL_AF_LO: begin
					next_s.paf_ofs[DATA_W-1:0] = pin_lvl.data;
					next_s.wr_sel = SEL_AF_HI;
				end
				SEL_AF_HI: begin
					next_s.paf_ofs[ADDR_W-1:DATA_W] = pin_lvl.data[HI_W-1:0];
					next_s.wr_sel = SEL_AE_LO;
				end
			endcase
		end
		if (ofs_read) begin
			unique case (s.rd_sel)
				SEL_AE_LO: begin
					next_s.out_data = s.pae_ofs[DATA_W-1:0];
					next_s.rd_sel = SEL_AE_HI;
				end
				SEL_AE_HI: begin
					next_s.out_data = {{(DATA_W-HI_W){1'b0}}, s.pae_ofs[ADDR_W-1:DATA_W]};
					next_s.rd_sel = SEL_AF_LO;
				end
				SEL_AF_LO: begin
					next_s.out_data = s.paf_ofs[DATA_W-1:0];
					next_s.rd_sel = SEL_AF_HI;
				end
				SEL_AF_HI: begin
					next_s.out_data = {{(DATA_W-HI_W){1'b0}}, s.paf_ofs[ADDR_W-1:DATA_W]};
					next_s.rd_sel = SEL_AE_LO;
				end
			endcase
		end

		// partial reset keeps mode and offsets, master reset restores them
		if (any_rst) begin
			next_s.wptr = PTR_ZERO;
			next_s.rptr = PTR_ZERO;
			next_s.wgray = PTR_ZERO;
			next_s.rgray = PTR_ZERO;
			next_s.out_data = DATA_ZERO;
			next_s.ov = 1'b0;
			next_s.hf_n = 1'b1;
			next_s.pae_n = 1'b0;
			next_s.paf_n = 1'b1;
			next_s.full_pin = !s.fall_through_mode;
			next_s.empty_pin = s.fall_through_mode;
			next_s.wr_sel = SEL_AE_LO;
			next_s.rd_sel = SEL_AE_LO;
		end
		if (master_reset_n) begin
			next_s.fall_through_mode = pin_lvl.fall_through_mode_si;
			next_s.serial = pin_lvl.ld_n;
			next_s.pae_ofs = pin_lvl.ld_n ? OFS_SER_DEFAULT : OFS_PAR_DEFAULT;
			next_s.paf_ofs = pin_lvl.ld_n ? OFS_SER_DEFAULT : OFS_PAR_DEFAULT;
			next_s.full_pin = !pin_lvl.fall_through_mode_si;
			next_s.empty_pin = pin_lvl.fall_through_mode_si;
		end
	end

	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s <= ST_INIT;
		end else begin
			s <= next_s;
		end
	end

	assign FULL_INPUT_READY_N_OUT = s.full_pin;
	assign EMPTY_OUTPUT_READY_N_OUT = s.empty_pin;
	assign ALMOST_EMPTY_FLAG_N_OUT = s.pae_n;
	assign ALMOST_FULL_FLAG_N_OUT = s.paf_n;
	assign HALF_FULL_FLAG_N_OUT = s.hf_n;
	assign READ_DATA_OUT = s.q_pin;
	assign READ_DATA_OE_N_OUT = s.oe_n;

	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (RST_IN);

	property p_write_advances;
		wr_accept |=> s.wptr == PTR_W'($past(s.wptr) + PTR_ONE);
	endproperty
	a_write_advances: assert property (p_write_advances) else $error("write not stored");

	property p_wen_high_holds;
		(wr_tick && pin_lvl.wen_n && !any_rst) |=> $stable(s.wptr);
	endproperty
	a_wen_high_holds: assert property (p_wen_high_holds) else $error("write without enable");

	property p_full_blocks;
		(wr_tick && full_int && !any_rst) |=> $stable(s.wptr);
	endproperty
	a_full_blocks: assert property (p_full_blocks) else $error("write while full");

	property p_full_release;
		(!s.fall_through_mode && wr_tick && pin_lvl.wen_n && !full_int && !any_rst) |=> s.full_pin;
	endproperty
	a_full_release: assert property (p_full_release) else $error("full flag not released");

	property p_empty_release;
		(!s.fall_through_mode && rd_tick && !std_take && !empty_int && !any_rst) |=> s.empty_pin;
	endproperty
	a_empty_release: assert property (p_empty_release) else $error("empty flag stuck");

	property p_read_flags_hold;
		(!s.fall_through_mode && !rd_tick && !any_rst)
			|=> $stable(s.empty_pin) && $stable(s.pae_n) && !$rose(s.hf_n);
	endproperty
	a_read_flags_hold: assert property (p_read_flags_hold) else $error("read flag moved");

	property p_ren_high_holds;
		(rd_tick && pin_lvl.ren_n && !any_rst && !ft_load) |=> $stable(s.out_data);
	endproperty
	a_ren_high_holds: assert property (p_ren_high_holds) else $error("output changed");

	property p_empty_no_read;
		(!s.fall_through_mode && rd_tick && empty_int && !any_rst) |=> $stable(s.rptr);
	endproperty
	a_empty_no_read: assert property (p_empty_no_read) else $error("read while empty");

	property p_ready_with_data;
		ft_load |=> s.ov ##1 (!EMPTY_OUTPUT_READY_N_OUT && READ_DATA_OUT == $past(s.out_data));
	endproperty
	a_ready_with_data: assert property (p_ready_with_data) else $error("ready misaligned");

	property p_drain_keeps_data;
		ft_drain |=> !s.ov && $stable(s.out_data);
	endproperty
	a_drain_keeps_data: assert property (p_drain_keeps_data) else $error("drain wrong");

	property p_sen_holds;
		(pin_lvl.sen_n && !master_reset_n && s.serial) |=> $stable(s.pae_ofs) && $stable(s.paf_ofs);
	endproperty
	a_sen_holds: assert property (p_sen_holds) else $error("offsets changed");

	property p_defaults;
		(master_reset_n && ld_active) |=> s.pae_ofs == OFS_PAR_DEFAULT && s.paf_ofs == OFS_PAR_DEFAULT
			&& !s.serial;
	endproperty
	a_defaults: assert property (p_defaults) else $error("bad default offsets");

	property p_reset_clears;
		any_rst |=> s.wptr == PTR_ZERO && s.rptr == PTR_ZERO && s.out_data == DATA_ZERO;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset incomplete");

	c_full: cover property (!s.fall_through_mode && !FULL_INPUT_READY_N_OUT);
	c_fall_through: cover property (ft_load ##[1:20] ft_drain);
	c_serial: cover property (ser_shift);
	c_readback: cover property (ofs_read);
endmodule : dcfpf_port_flags

// [core/dcfpf_pkg.sv]
package dcfpf_pkg;
	localparam int DATA_W = 9;
	localparam int ADDR_W = 14;
	localparam int PTR_W = 15;
	localparam int HI_W = ADDR_W - DATA_W;
	localparam logic [PTR_W-1:0] DEPTH = 15'h4000;
	localparam logic [PTR_W-1:0] HALF_DEPTH = 15'h2000;
	localparam logic [PTR_W-1:0] PTR_ZERO = 15'h0000;
	localparam logic [PTR_W-1:0] PTR_ONE = 15'h0001;
	localparam logic [ADDR_W-1:0] OFS_PAR_DEFAULT = 14'h007f;
	localparam logic [ADDR_W-1:0] OFS_SER_DEFAULT = 14'h03ff;
	localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;

	// order of offset chunks on the data bus for parallel write and readback
	typedef enum logic [1:0] {
		SEL_AE_LO = 2'b00,
		SEL_AE_HI = 2'b01,
		SEL_AF_LO = 2'b10,
		SEL_AF_HI = 2'b11
	} dcfpf_sel_t;

	// pins as seen after the three-flop samplers
	typedef struct packed {
		logic wclk;
		logic rclk;
		logic wen_n;
		logic ren_n;
		logic oe_n;
		logic mrs_n;
		logic prs_n;
		logic ld_n;
		logic sen_n;
		logic fall_through_mode_si;
		logic [DATA_W-1:0] data;
	} dcfpf_pins_t;

	localparam int PIN_W = $bits(dcfpf_pins_t);

	typedef struct packed {
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [PTR_W-1:0] wgray;
		logic [PTR_W-1:0] rgray;
		logic [DATA_W-1:0] out_data;
		logic ov;
		logic fall_through_mode;
		logic serial;
		logic [ADDR_W-1:0] pae_ofs;
		logic [ADDR_W-1:0] paf_ofs;
		dcfpf_sel_t wr_sel;
		dcfpf_sel_t rd_sel;
		logic hf_n;
		logic pae_n;
		logic paf_n;
		logic full_pin;
		logic empty_pin;
		logic oe_n;
		logic [DATA_W-1:0] q_pin;
	} dcfpf_state_t;

	function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray2bin
endpackage : dcfpf_pkg

// [core/dcfpf_pin_sync.sv]
`timescale 1ns/1ps
module dcfpf_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] level_out,
	output logic [W-1:0] rise_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] level;
		logic [W-1:0] rise;
	} dcfpf_sync_st_t;

	dcfpf_sync_st_t s;
	dcfpf_sync_st_t next_s;

	// a bit counts as changed once stages two and three agree
	always_comb begin
		next_s = s;
		next_s.s1 = d_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		next_s.level = (s.s2 & s.s3) | (s.level & (s.s2 | s.s3));
		next_s.rise = next_s.level & ~s.level;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level_out = s.level;
	assign rise_out = s.rise;
endmodule : dcfpf_pin_sync

// [core/dcfpf_gray_sync.sv]
`timescale 1ns/1ps
module dcfpf_gray_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] gray_in,
	output logic [W-1:0] gray_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dcfpf_gsync_st_t;

	dcfpf_gsync_st_t s;
	dcfpf_gsync_st_t next_s;

	// two stages of pointer latency between the write and read sides
	always_comb begin
		next_s.s1 = gray_in;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign gray_out = s.s2;
endmodule : dcfpf_gray_sync

// [tb/dcfpf_tb_partner.sv]
`timescale 1ns/1ps
module dcfpf_tb_partner (
	input wire logic mclk_in,
	output logic wclk_out,
	output logic rclk_out,
	output logic wen_n_out,
	output logic ren_n_out,
	output logic [dcfpf_pkg::DATA_W-1:0] wdata_out
);
	import dcfpf_pkg::*;

	initial begin
		wclk_out = 1'b0;
		rclk_out = 1'b0;
		wen_n_out = 1'b1;
		ren_n_out = 1'b1;
		wdata_out = 9'h000;
	end

	// one write-clock pulse, high for four system clocks; clock idles low between words
	task automatic write_word(input logic [DATA_W-1:0] d, input logic en_n);
		@(posedge mclk_in);
		wen_n_out <= en_n;
		wdata_out <= d;
		repeat (4) @(posedge mclk_in);
		wclk_out <= 1'b1;
		repeat (4) @(posedge mclk_in);
		wclk_out <= 1'b0;
		wen_n_out <= 1'b1;
		// released bus shows the inverse, not the stale word
		wdata_out <= ~d;
		repeat (6) @(posedge mclk_in);
	endtask : write_word

	// reader asks for every word with its own enable, also offset readback
	task automatic read_word(input logic en_n);
		@(posedge mclk_in);
		ren_n_out <= en_n;
		repeat (4) @(posedge mclk_in);
		rclk_out <= 1'b1;
		repeat (4) @(posedge mclk_in);
		rclk_out <= 1'b0;
		ren_n_out <= 1'b1;
		repeat (6) @(posedge mclk_in);
	endtask : read_word
endmodule : dcfpf_tb_partner

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	import dcfpf_pkg::*;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic oe_n = 1'b1;
	logic mrs_n = 1'b1;
	logic prs_n = 1'b1;
	logic ld_n = 1'b1;
	logic fall_through_mode = 1'b0;
	logic wclk, rclk, wen_n, ren_n;
	logic [DATA_W-1:0] wdata;
	logic full_n, empty_n, oe_out_n;
	logic ser_en_n = 1'b1;
	logic ae_n, af_n, half_n;
	// almost-full offset then almost-empty offset, shifted in from the top bit
	localparam logic [2*ADDR_W-1:0] SER_OFS = {14'h0000, 14'h0002};
	logic [DATA_W-1:0] rdata;
	int fail_count = 0;
	int cmp_count = 0;

	always #12.5 mclk = ~mclk;

	dcfpf_tb_partner partner (
		.mclk_in(mclk),
		.wclk_out(wclk),
		.rclk_out(rclk),
		.wen_n_out(wen_n),
		.ren_n_out(ren_n),
		.wdata_out(wdata)
	);

	dcfpf_port_flags dut (
		.MCLK_IN(mclk),
		.RST_IN(rst),
		.WRITE_CLK_IN(wclk),
		.READ_CLK_IN(rclk),
		.WRITE_EN_N_IN(wen_n),
		.READ_EN_N_IN(ren_n),
		.OUTPUT_EN_N_IN(oe_n),
		.MASTER_RESET_N_IN(mrs_n),
		.PARTIAL_RESET_N_IN(prs_n),
		.OFFSET_ACCESS_N_IN(ld_n),
		.SERIAL_PROG_ENABLE_N_IN(ser_en_n),
		.FALL_THROUGH_MODE_IN(fall_through_mode),
		.WRITE_DATA_IN(wdata),
		.FULL_INPUT_READY_N_OUT(full_n),
		.EMPTY_OUTPUT_READY_N_OUT(empty_n),
		.ALMOST_EMPTY_FLAG_N_OUT(ae_n),
		.ALMOST_FULL_FLAG_N_OUT(af_n),
		.HALF_FULL_FLAG_N_OUT(half_n),
		.READ_DATA_OUT(rdata),
		.READ_DATA_OE_N_OUT(oe_out_n)
	);

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
	endtask : settle

	// mode and load straps are held across the master reset pulse
	task automatic mreset(input logic mode, input logic ld);
		@(posedge mclk);
		mrs_n <= 1'b0;
		fall_through_mode <= mode;
		ld_n <= ld;
		settle(10);
		mrs_n <= 1'b1;
		settle(10);
	endtask : mreset

	initial begin
		settle(20);
		rst <= 1'b0;
		settle(10);
		// standard mode, parallel defaults
		mreset(1'b0, 1'b0);
		check({8'h00, empty_n}, 9'h000);
		check({8'h00, full_n}, 9'h001);
		partner.read_word(1'b0);
		check(rdata, OFS_PAR_DEFAULT[DATA_W-1:0]);
		ld_n <= 1'b1;
		partner.write_word(9'h1a5, 1'b0);
		partner.write_word(9'h05a, 1'b0);
		partner.write_word(9'h1ff, 1'b1);
		partner.write_word(9'h100, 1'b0);
		repeat (3) partner.read_word(1'b1);
		check({8'h00, empty_n}, 9'h001);
		check(rdata, OFS_PAR_DEFAULT[DATA_W-1:0]);
		partner.read_word(1'b0);
		check(rdata, 9'h1a5);
		partner.read_word(1'b0);
		check(rdata, 9'h05a);
		partner.read_word(1'b0);
		check(rdata, 9'h100);
		check({8'h00, empty_n}, 9'h000);
		partner.read_word(1'b0);
		check(rdata, 9'h100);
		@(posedge mclk);
		oe_n <= 1'b0;
		settle(6);
		check({8'h00, oe_out_n}, 9'h000);
		oe_n <= 1'b1;
		settle(6);
		check({8'h00, oe_out_n}, 9'h001);
		$display("test standard mode done");
		// fall-through mode
		mreset(1'b1, 1'b1);
		check({8'h00, empty_n}, 9'h001);
		check({8'h00, full_n}, 9'h000);
		partner.write_word(9'h0c3, 1'b0);
		partner.write_word(9'h13c, 1'b0);
		repeat (3) partner.read_word(1'b1);
		check(rdata, 9'h0c3);
		check({8'h00, empty_n}, 9'h000);
		partner.read_word(1'b0);
		check(rdata, 9'h13c);
		check({8'h00, empty_n}, 9'h000);
		partner.read_word(1'b1);
		check({8'h00, empty_n}, 9'h000);
		partner.read_word(1'b0);
		check({8'h00, empty_n}, 9'h001);
		check(rdata, 9'h13c);
		partner.read_word(1'b0);
		check(rdata, 9'h13c);
		$display("test fall-through mode done");
		// partial reset keeps the mode, clears data
		partner.write_word(9'h0f0, 1'b0);
		@(posedge mclk);
		prs_n <= 1'b0;
		settle(10);
		prs_n <= 1'b1;
		settle(10);
		check(rdata, DATA_ZERO);
		check({8'h00, empty_n}, 9'h001);
		partner.write_word(9'h011, 1'b0);
		repeat (3) partner.read_word(1'b1);
		check(rdata, 9'h011);
		$display("test partial reset done");
		// serial offset programming in standard mode
		mreset(1'b0, 1'b1);
		check({8'h00, ae_n}, 9'h000);
		check({8'h00, af_n}, 9'h001);
		check({8'h00, half_n}, 9'h001);
		ld_n <= 1'b0;
		ser_en_n <= 1'b0;
		for (int i = 2 * ADDR_W - 1; i >= 0; i--) begin
			fall_through_mode <= SER_OFS[i];
			partner.write_word(9'h000, 1'b1);
		end
		ser_en_n <= 1'b1;
		fall_through_mode <= 1'b1;
		partner.write_word(9'h000, 1'b1);
		partner.read_word(1'b0);
		check(rdata, SER_OFS[DATA_W-1:0]);
		ld_n <= 1'b1;
		partner.write_word(9'h031, 1'b0);
		partner.write_word(9'h032, 1'b0);
		partner.write_word(9'h033, 1'b0);
		check({8'h00, empty_n}, 9'h000);
		check({8'h00, ae_n}, 9'h000);
		partner.read_word(1'b1);
		check({8'h00, empty_n}, 9'h001);
		check({8'h00, ae_n}, 9'h001);
		partner.read_word(1'b0);
		check(rdata, 9'h031);
		check({8'h00, ae_n}, 9'h000);
		check({8'h00, half_n}, 9'h001);
		check({8'h00, af_n}, 9'h001);
		$display("test serial offsets done");
		end_of_test();
	end

	initial begin
		settle(20000);
		fail_count++;
		end_of_test();
	end
endmodule : tb
